// *** fieldbus_timeout_config.sv ***
// fieldbus cyclic-frame watchdog with configuration registers
// assumes connect/frame/event strobes from same-clock logic
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_timeout_config
	import fieldbus_timeout_config_pkg::*;
(
	input  wire logic         i_clk_sys,
	input  wire logic         i_sys_rst,
	input  wire logic [4:0]   i_avs_address,
	input  wire logic         i_avs_read,
	input  wire logic         i_avs_write,
	input  wire logic [31:0]  i_avs_writedata,
	input  wire logic [3:0]   i_avs_byteenable,
	output logic [31:0]       o_avs_readdata,
	output logic              o_avs_waitrequest,
	input  wire connect_req_s i_connect,
	input  wire logic         i_cyclic_frame,
	input  wire logic         i_slot_change,
	input  wire logic         i_param_write_activated,
	input  wire logic         i_user_save,
	input  wire logic         i_restore_defaults,
	output timeout_act_s      o_timeout_act,
	output logic [7:0]        o_event_target,
	output logic [7:0]        o_event_kind
);
	state_s r;
	state_s next_r;
	logic   wr_hit;
	logic   rd_hit;
	logic   bump;
	logic   full_word;
	logic [15:0] tmo_in;

	// writes finish at once; reads take one extra cycle for registered data
	assign wr_hit            = i_avs_write;
	assign rd_hit            = i_avs_read && r.rd_pend;
	assign o_avs_waitrequest = i_avs_read && !r.rd_pend;
	assign o_avs_readdata    = r.readdata;
	assign o_timeout_act     = r.act;
	assign o_event_target    = r.timeout_event_target;
	assign o_event_kind      = r.timeout_event_kind;
	assign full_word         = &i_avs_byteenable[1:0];

	always_comb begin
		next_r  = r;
		tmo_in  = i_avs_writedata[15:0];
		bump    = i_slot_change || i_param_write_activated || i_user_save;

		// parameter writes over the bus
		next_r.rd_pend = i_avs_read && !r.rd_pend;
		if (wr_hit && full_word) begin
			case (i_avs_address)
				ADDR_TMO: begin
					// out-of-range values are refused, keeping the old period
					if (tmo_in >= TMO_MIN_MS && tmo_in <= TMO_MAX_MS) begin
						next_r.cyclic_timeout_period = tmo_in;
					end
				end
				ADDR_ACTION: begin
					if (i_avs_writedata[7:0] <= ACT_NONE) begin
						next_r.timeout_action_select = i_avs_writedata[7:0];
					end
				end
				ADDR_TARGET: begin
					if (i_avs_writedata[7:0] <= TARGET_MAX) begin
						next_r.timeout_event_target = i_avs_writedata[7:0];
					end
				end
				ADDR_KIND: begin
					if (i_avs_writedata[7:0] <= KIND_MAX) begin
						next_r.timeout_event_kind = i_avs_writedata[7:0];
					end
				end
				// date is read-only over the bus: only a connect request with date_valid sets it
				default: begin
					next_r.readdata = r.readdata;
				end
			endcase
		end

		if (i_avs_read && !r.rd_pend) begin
			case (i_avs_address)
				ADDR_ERR:     next_r.readdata = {24'h000000, r.config_error_code};
				ADDR_REV:     next_r.readdata = {16'h0000, r.revision_counter};
				ADDR_PROFILE: next_r.readdata = {16'h0000, PROFILE_ID};
				ADDR_DATE:    next_r.readdata = r.installation_date;
				ADDR_TMO:     next_r.readdata = {16'h0000, r.cyclic_timeout_period};
				ADDR_ACTION:  next_r.readdata = {24'h000000, r.timeout_action_select};
				ADDR_TARGET:  next_r.readdata = {24'h000000, r.timeout_event_target};
				ADDR_KIND:    next_r.readdata = {24'h000000, r.timeout_event_kind};
				default:      next_r.readdata = UNMAPPED_READ;
			endcase
		end

		// revision counter; defaults win over an increment in the same cycle
		if (i_restore_defaults) begin
			next_r.revision_counter = 16'h0000;
		end else if (bump) begin
			if (r.revision_counter == REV_MAX) begin
				next_r.revision_counter = REV_FIRST;
			end else begin
				next_r.revision_counter = r.revision_counter + REV_FIRST;
			end
		end

		// connect request: error code, timeout and date refresh
		if (i_connect.valid) begin
			if (i_connect.in_slots > {2'b00, MAX_SLOTS}) begin
				next_r.config_error_code = ERR_IN_MAP;
			end else if (i_connect.out_slots > {2'b00, MAX_SLOTS}) begin
				next_r.config_error_code = ERR_OUT_MAP;
			end else if (i_connect.size_mismatch) begin
				next_r.config_error_code = ERR_SIZE;
			end else if (i_connect.param_invalid) begin
				next_r.config_error_code = ERR_PARAM;
			end else begin
				next_r.config_error_code = ERR_NONE;
			end
			if (i_connect.timeout_ms >= TMO_MIN_MS && i_connect.timeout_ms <= TMO_MAX_MS) begin
				next_r.cyclic_timeout_period = i_connect.timeout_ms;
			end
			if (i_connect.date_valid) begin
				next_r.installation_date = i_connect.date;
			end
		end

		// supervision of cyclic frames
		case (r.state)
			SUP_IDLE: begin
				next_r.cyc_cnt = 17'h00000;
				next_r.ms_cnt  = 16'h0000;
				if (i_cyclic_frame) begin
					next_r.state = SUP_WATCH;
				end
			end
			SUP_WATCH: begin
				if (i_cyclic_frame || i_connect.valid) begin
					next_r.cyc_cnt = 17'h00000;
					next_r.ms_cnt  = 16'h0000;
				end else if (r.cyc_cnt == CYC_PER_MS - 17'h00001) begin
					next_r.cyc_cnt = 17'h00000;
					next_r.ms_cnt  = r.ms_cnt + 16'h0001;
					if (r.ms_cnt + 16'h0001 >= r.cyclic_timeout_period) begin
						next_r.state = SUP_EXPIRED;
					end
				end else begin
					next_r.cyc_cnt = r.cyc_cnt + 17'h00001;
				end
			end
			SUP_EXPIRED: begin
				next_r.cyc_cnt = 17'h00000;
				next_r.ms_cnt  = 16'h0000;
				if (i_cyclic_frame) begin
					next_r.state = SUP_WATCH;
				end
			end
			default: begin
				next_r.state = SUP_IDLE;
			end
		endcase

		// output action, held while expired
		next_r.act = '0;
		if (next_r.state == SUP_EXPIRED) begin
			next_r.act.timed_out = 1'b1;
			case (r.timeout_action_select)
				ACT_TRIP:       next_r.act.trip = 1'b1;
				ACT_FAULT_VALS: next_r.act.apply_fault_values = 1'b1;
				ACT_CLEAR:      next_r.act.clear_outputs = 1'b1;
				ACT_HOLD:       next_r.act.hold_last = 1'b1;
				default:        next_r.act.timed_out = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			r                       <= '0;
			r.state                 <= SUP_IDLE;
			r.config_error_code     <= ERR_NONE;
			r.revision_counter      <= 16'h0000;
			r.cyclic_timeout_period <= TMO_DEF_MS;
			r.timeout_action_select <= ACT_NONE;
			r.timeout_event_target  <= TARGET_DEF;
			r.timeout_event_kind    <= KIND_DEF;
		end else begin
			r <= next_r;
		end
	end
endmodule
`default_nettype wire

// *** fieldbus_timeout_config_pkg.sv ***
// package for the fieldbus timeout and configuration block
// assumes a 100 MHz system clock and an Avalon-MM register slave
package fieldbus_timeout_config_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned CYC_PER_MS_I    = CLK_HZ / MS_PER_S;
	localparam logic [16:0] CYC_PER_MS      = CYC_PER_MS_I[16:0];
	localparam logic [15:0] TMO_MIN_MS      = 16'h0001;
	localparam logic [15:0] TMO_MAX_MS      = 16'h2710;
	localparam logic [15:0] TMO_DEF_MS      = 16'h0064;
	localparam logic [5:0]  MAX_SLOTS       = 6'h20;
	localparam logic [15:0] REV_MAX         = 16'hFFFF;
	localparam logic [15:0] REV_FIRST       = 16'h0001;
	localparam logic [15:0] PROFILE_ID      = 16'hF600;

	localparam logic [7:0] ERR_NONE        = 8'h00;
	localparam logic [7:0] ERR_IN_MAP      = 8'h01;
	localparam logic [7:0] ERR_OUT_MAP     = 8'h02;
	localparam logic [7:0] ERR_SIZE        = 8'h03;
	localparam logic [7:0] ERR_PARAM       = 8'h04;

	localparam logic [7:0] ACT_TRIP        = 8'h00;
	localparam logic [7:0] ACT_FAULT_VALS  = 8'h01;
	localparam logic [7:0] ACT_CLEAR       = 8'h02;
	localparam logic [7:0] ACT_HOLD        = 8'h03;
	localparam logic [7:0] ACT_NONE        = 8'h04;
	localparam logic [7:0] TARGET_MAX      = 8'h04;
	localparam logic [7:0] KIND_MAX        = 8'h05;
	localparam logic [7:0] TARGET_DEF      = 8'h00;
	localparam logic [7:0] KIND_DEF        = 8'h00;

	// byte addresses of the register words
	localparam logic [4:0] ADDR_ERR        = 5'h00;
	localparam logic [4:0] ADDR_REV        = 5'h04;
	localparam logic [4:0] ADDR_PROFILE    = 5'h08;
	localparam logic [4:0] ADDR_DATE       = 5'h0C;
	localparam logic [4:0] ADDR_TMO        = 5'h10;
	localparam logic [4:0] ADDR_ACTION     = 5'h14;
	localparam logic [4:0] ADDR_TARGET     = 5'h18;
	localparam logic [4:0] ADDR_KIND       = 5'h1C;
	localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

	typedef enum logic [1:0] {
		SUP_IDLE    = 2'b00,
		SUP_WATCH   = 2'b01,
		SUP_EXPIRED = 2'b11
	} sup_state_e;

	// one connect request from the controller
	typedef struct packed {
		logic        valid;
		logic [7:0]  in_slots;
		logic [7:0]  out_slots;
		logic        size_mismatch;
		logic        param_invalid;
		logic [15:0] timeout_ms;
		logic        date_valid;
		logic [31:0] date;
	} connect_req_s;

	// outgoing output-mapping control on timeout
	typedef struct packed {
		logic trip;
		logic apply_fault_values;
		logic clear_outputs;
		logic hold_last;
		logic timed_out;
	} timeout_act_s;

	typedef struct packed {
		sup_state_e  state;
		logic [16:0] cyc_cnt;
		logic [15:0] ms_cnt;
		logic [7:0]  config_error_code;
		logic [15:0] revision_counter;
		logic [31:0] installation_date;
		logic [15:0] cyclic_timeout_period;
		logic [7:0]  timeout_action_select;
		logic [7:0]  timeout_event_target;
		logic [7:0]  timeout_event_kind;
		logic        rd_pend;
		logic [31:0] readdata;
		timeout_act_s act;
	} state_s;
endpackage

// *** fieldbus_timeout_config_props.sv ***
// checker: register bus, watchdog action and event-setting properties
// assumes it is bound to the watchdog top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module fieldbus_timeout_config_props
	import fieldbus_timeout_config_pkg::*;
(
	input wire logic         i_clk_sys,
	input wire logic         i_sys_rst,
	input wire logic [4:0]   i_avs_address,
	input wire logic         i_avs_read,
	input wire logic         i_avs_write,
	input wire logic [31:0]  o_avs_readdata,
	input wire logic         o_avs_waitrequest,
	input wire connect_req_s i_connect,
	input wire logic         i_cyclic_frame,
	input wire timeout_act_s o_timeout_act,
	input wire logic [7:0]   o_event_target,
	input wire logic [7:0]   o_event_kind
);
	logic [16:0] gap;
	timeout_act_s a;
	assign a = o_timeout_act;
	// saturates so a long idle stretch cannot wrap into a false short gap
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_cyclic_frame || i_connect.valid)
			gap <= 17'h0;
		else if (gap != 17'h1FFFF)
			gap <= gap + 17'h1;
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	rd_wait_once_a: assert property (i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("read waits longer than one cycle");
	profile_read_a: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address == ADDR_PROFILE |-> o_avs_readdata == {16'h0000, PROFILE_ID})
		else $error("profile identifier read wrong");
	expiry_gap_a: assert property ($rose(a.timed_out) |-> gap >= 17'h1869E)
		else $error("timeout before one millisecond without frame");
	frame_clears_a: assert property (i_cyclic_frame |-> ##1 !a.timed_out)
		else $error("frame did not clear timeout");
	trip_only_a: assert property (a.trip |-> a.timed_out && !a.apply_fault_values)
		else $error("trip without timeout");
	fault_vals_a: assert property (a.apply_fault_values |-> a.timed_out && !a.hold_last)
		else $error("fault values without timeout");
	clear_out_a: assert property (a.clear_outputs |-> a.timed_out && !a.trip)
		else $error("clear outputs without timeout");
	hold_last_a: assert property (a.hold_last |-> a.timed_out && !a.clear_outputs)
		else $error("hold last without timeout");
	event_range_a: assert property (o_event_target <= TARGET_MAX && o_event_kind <= KIND_MAX)
		else $error("event setting out of range");
	event_kept_a: assert property (!i_avs_write |=> $stable({o_event_target, o_event_kind}))
		else $error("event setting changed without write");
	cover property ($rose(a.timed_out));
	cover property (i_avs_read && !o_avs_waitrequest);
	cover property (i_connect.valid);
endmodule
bind fieldbus_timeout_config fieldbus_timeout_config_props u_props (.*);
`default_nettype wire

// *** plc_model.sv ***
// controller model: sends connect requests and cyclic frames
// assumes the bench calls its tasks just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module plc_model
	import fieldbus_timeout_config_pkg::*;
(
	input  wire logic    i_clk_sys,
	output connect_req_s o_connect,
	output logic         o_frame
);
	initial begin
		o_connect = '0;
		o_frame = 1'b0;
	end
	task automatic connect(input logic [7:0] ins, input logic [7:0] outs, input logic sz,
		input logic pv, input logic [15:0] tmo, input logic [31:0] date);
		connect_req_s r;
		r = '{1'b1, ins, outs, sz, pv, tmo, 1'b1, date};
		o_connect <= r;
		@(posedge i_clk_sys);
		// released fields toggle so a stale value is never mistaken for data
		r = ~r;
		r.valid = 1'b0;
		r.date_valid = 1'b0;
		o_connect <= r;
	endtask
	task automatic frame();
		o_frame <= 1'b1;
		@(posedge i_clk_sys);
		o_frame <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** tb_fieldbus_timeout_config.sv ***
// bench: register table, connect errors, revision counter, watchdog
// assumes the controller model drives the connect and frame inputs
`timescale 1ns/10ps
`default_nettype none
module tb_fieldbus_timeout_config
	import fieldbus_timeout_config_pkg::*;
;
	typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e;} row_s;
	logic clk, rst, rd, wr, wt, sl, pw, sv, df, frm;
	logic [4:0] adr;
	logic [3:0] be;
	logic [31:0] wd, rdata, q;
	logic [7:0] tgt, knd;
	connect_req_s conn;
	timeout_act_s act;
	int fails, comparisons, n;
	row_s rows [16] = '{
		'{1'b0, ADDR_ERR, 32'h0, 4'hF, 32'h0}, '{1'b0, ADDR_REV, 32'h0, 4'hF, 32'h0},
		'{1'b0, ADDR_PROFILE, 32'h0, 4'hF, 32'hF600}, '{1'b0, ADDR_TMO, 32'h0, 4'hF, 32'h64},
		'{1'b0, ADDR_ACTION, 32'h0, 4'hF, 32'h4}, '{1'b0, ADDR_TARGET, 32'h0, 4'hF, 32'h0},
		'{1'b0, ADDR_KIND, 32'h0, 4'hF, 32'h0}, '{1'b1, ADDR_PROFILE, 32'h1, 4'hF, 32'hF600},
		'{1'b1, ADDR_DATE, 32'h5, 4'hF, 32'h0}, '{1'b1, ADDR_TMO, 32'h2711, 4'hF, 32'h64},
		'{1'b1, ADDR_TMO, 32'h2710, 4'hF, 32'h2710}, '{1'b1, ADDR_ACTION, 32'h2, 4'h1, 32'h4},
		'{1'b1, ADDR_ACTION, 32'h1, 4'h3, 32'h1}, '{1'b1, ADDR_TARGET, 32'h5, 4'hF, 32'h0},
		'{1'b1, ADDR_TARGET, 32'h4, 4'hF, 32'h4}, '{1'b1, ADDR_KIND, 32'h5, 4'hF, 32'h5}};
	plc_model plc (.i_clk_sys(clk), .o_connect(conn), .o_frame(frm));
	fieldbus_timeout_config dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_connect(conn),
		.i_cyclic_frame(frm), .i_slot_change(sl), .i_param_write_activated(pw),
		.i_user_save(sv), .i_restore_defaults(df), .o_timeout_act(act),
		.o_event_target(tgt), .o_event_kind(knd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// one idle edge after each transfer so no strobe is set twice in a step
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
		int k;
		k = 0;
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		be <= b;
		do begin
			@(posedge clk);
			k++;
		end while (wt !== 1'b0 && k < 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (k >= 20) begin
			fails++;
			finish_test();
		end
		@(posedge clk);
	endtask
	initial begin
		{rst, rd, wr, sl, pw, sv, df} = 7'h40;
		adr = 5'h0;
		wd = 32'h0;
		be = 4'hF;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w)
				bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
			bus(1'b0, rows[i].a, 32'h0, 4'hF);
			chk("register", rows[i].e, q);
		end
		chk("event", 32'h0405, {16'h0, tgt, knd});
		for (int i = 0; i < 5; i++) begin
			plc.connect((i == 0) ? 8'h21 : 8'h20, (i < 2) ? 8'h21 : 8'h20, i == 2,
				i == 2 || i == 3, 16'h0001, 32'h1200_0000 + 32'(i));
			bus(1'b0, ADDR_ERR, 32'h0, 4'hF);
			chk("error", (i < 4) ? 32'(i + 1) : 32'h0, q);
		end
		bus(1'b0, ADDR_TMO, 32'h0, 4'hF);
		chk("timeout", 32'h1, q);
		bus(1'b0, ADDR_DATE, 32'h0, 4'hF);
		chk("date", 32'h1200_0004, q);
		for (int i = 0; i < 4; i++) begin
			{sl, pw, sv} <= (i == 3) ? 3'h7 : 3'h4 >> i;
			@(posedge clk);
			{sl, pw, sv} <= 3'h0;
			bus(1'b0, ADDR_REV, 32'h0, 4'hF);
			chk("revision", 32'(i + 1), q);
		end
		{df, sl} <= 2'h3;
		@(posedge clk);
		{df, sl} <= 2'h0;
		bus(1'b0, ADDR_REV, 32'h0, 4'hF);
		chk("revision", 32'h0, q);
		plc.frame();
		repeat (99990) @(posedge clk);
		chk("early", 32'h0, 32'(act));
		n = 0;
		while (act.timed_out !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40) begin
			fails++;
			finish_test();
		end
		@(posedge clk);
		chk("expired", 32'h9, 32'(act));
		plc.frame();
		repeat (3) @(posedge clk);
		chk("rearmed", 32'h0, 32'(act));
		finish_test();
	end
endmodule
`default_nettype wire
